// ### design/rx_statistics_counters.sv
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`include "rxsc_cfg.svh"

// Contract
// (R1) Counters are 64 bits and wrap
// (R2) Frame size covers addresses, payload, CRC
// (R3) Stats excluded: no counters, reads zero
// (R4) Reads never disturb counter values
// (R5) Control register clears all counters together
// (R6) Shadow bit set captures consistent snapshot
// (R7) Shadow held: counters run, reads frozen
// (R8) Each counter: low word even, high odd
// (R9) Short frame with CRC error counted
// (R10) Oversized frame with CRC error counted
// (R11) Every check-sequence error pulse counted; pulses while ce is low or a clear is pending are not counted
// (R12) Frame of 64 or more, CRC error
// (R13) Errored data frames counted per cast
// (R14) Errored control frames counted per cast
// (R15) Errored pause frames counted
// (R16) Exactly 64-byte frames counted
// (R17) Oversized means above maximum size register
// (R18) Clear bit zero, self-clearing after reset
// (R19) One increment per event, none lost; events while ce is low or a clear is pending are dropped
module rx_statistics_counters #(
    parameter bit ENABLE_RX_STATS = 1'b1
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire rxsc_pkg::rxsc_apb_req_type apbReq,
    output rxsc_pkg::rxsc_apb_rsp_type apbRsp,
    input wire rxsc_pkg::rxsc_frame_type frameEvt,
    input wire logic checkSeqErrPulse
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    localparam rxsc_pkg::rxsc_state_type RESET_STATE = '{
        cnt: '0,
        snap: '0,
        ctlClear: 1'b0,
        ctlShadow: 1'b0,
        maxSize: `RXSC_MAXSZ_RESET,
        prdata: 32'h0000_0000
    };

    rxsc_pkg::rxsc_state_type s_reg;
    rxsc_pkg::rxsc_state_type s_next;
    logic [`RXSC_NUM_CNT-1:0] incVec;
    logic [13:0] wordIdx;
    logic aligned;
    logic setupPhase;
    logic accessPhase;
    logic writeTaken;
    logic frameErr;
    logic shortFrame;
    logic overSize;
    logic minFrame;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic logic rxsc_is_cnt(input logic [13:0] idx);
        rxsc_is_cnt = (idx >= `RXSC_CNT_BASE_IDX) && (idx <= `RXSC_CNT_LAST_IDX);
    endfunction : rxsc_is_cnt

    function automatic logic rxsc_hit(input logic [13:0] idx);
        rxsc_hit = rxsc_is_cnt(idx)
            || (idx == `RXSC_CTL_IDX)
            || (idx == `RXSC_STAT_IDX)
            || (idx == `RXSC_MAXSZ_IDX);
    endfunction : rxsc_hit

    // ----------------------------------------
    // Counter access
    // ----------------------------------------
    // Snapshot while frozen, live count otherwise
    function automatic logic [63:0] rxsc_view(
        input rxsc_pkg::rxsc_state_type st,
        input logic [3:0] slot
    );
        rxsc_view = 64'h0000_0000_0000_0000;
        if (ENABLE_RX_STATS)  // R3
        begin
            rxsc_view = st.ctlShadow ? st.snap[slot] : st.cnt[slot];  // R7
        end
    endfunction : rxsc_view

    // Plain add, wraps to zero past the top
    function automatic logic [63:0] rxsc_inc(input logic [63:0] v);
        rxsc_inc = v + 64'h0000_0000_0000_0001;  // R1
    endfunction : rxsc_inc

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    function automatic logic [31:0] rxsc_read(
        input rxsc_pkg::rxsc_state_type st,
        input logic [13:0] idx
    );
        logic [63:0] word;
        word = 64'h0000_0000_0000_0000;
        rxsc_read = 32'h0000_0000;
        case (idx)
            `RXSC_SHORT_LO_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_SHORT);
                rxsc_read = word[31:0];  // R8
            end
            `RXSC_SHORT_HI_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_SHORT);
                rxsc_read = word[63:32];  // R8
            end
            `RXSC_LONG_LO_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_LONG);
                rxsc_read = word[31:0];  // R8
            end
            `RXSC_LONG_HI_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_LONG);
                rxsc_read = word[63:32];  // R8
            end
            `RXSC_CHKSEQ_LO_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_FCS);
                rxsc_read = word[31:0];  // R8
            end
            `RXSC_CHKSEQ_HI_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_FCS);
                rxsc_read = word[63:32];  // R8
            end
            `RXSC_CRC_LO_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_CRC);
                rxsc_read = word[31:0];  // R8
            end
            `RXSC_CRC_HI_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_CRC);
                rxsc_read = word[63:32];  // R8
            end
            `RXSC_MDATA_LO_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_MDATA);
                rxsc_read = word[31:0];  // R8
            end
            `RXSC_MDATA_HI_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_MDATA);
                rxsc_read = word[63:32];  // R8
            end
            `RXSC_BDATA_LO_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_BDATA);
                rxsc_read = word[31:0];  // R8
            end
            `RXSC_BDATA_HI_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_BDATA);
                rxsc_read = word[63:32];  // R8
            end
            `RXSC_UDATA_LO_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_UDATA);
                rxsc_read = word[31:0];  // R8
            end
            `RXSC_UDATA_HI_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_UDATA);
                rxsc_read = word[63:32];  // R8
            end
            `RXSC_MCTL_LO_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_MCTL);
                rxsc_read = word[31:0];  // R8
            end
            `RXSC_MCTL_HI_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_MCTL);
                rxsc_read = word[63:32];  // R8
            end
            `RXSC_BCTL_LO_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_BCTL);
                rxsc_read = word[31:0];  // R8
            end
            `RXSC_BCTL_HI_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_BCTL);
                rxsc_read = word[63:32];  // R8
            end
            `RXSC_UCTL_LO_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_UCTL);
                rxsc_read = word[31:0];  // R8
            end
            `RXSC_UCTL_HI_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_UCTL);
                rxsc_read = word[63:32];  // R8
            end
            `RXSC_FLOW_LO_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_FLOW);
                rxsc_read = word[31:0];  // R8
            end
            `RXSC_FLOW_HI_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_FLOW);
                rxsc_read = word[63:32];  // R8
            end
            `RXSC_MIN_LO_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_MIN);
                rxsc_read = word[31:0];  // R8
            end
            `RXSC_MIN_HI_IDX:
            begin
                word = rxsc_view(st, `RXSC_C_MIN);
                rxsc_read = word[63:32];  // R8
            end
            `RXSC_CTL_IDX:
            begin
                rxsc_read[`RXSC_CTL_CLEAR_BIT] = st.ctlClear;
                rxsc_read[`RXSC_CTL_SHADOW_BIT] = st.ctlShadow;
            end
            `RXSC_STAT_IDX:
            begin
                rxsc_read[`RXSC_STAT_PAUSED_BIT] = st.ctlShadow;
            end
            `RXSC_MAXSZ_IDX:
            begin
                rxsc_read[15:0] = st.maxSize;
            end
            default:
            begin
                // Unmapped words read zero
                rxsc_read = 32'h0000_0000;
            end
        endcase
    endfunction : rxsc_read

    // ----------------------------------------
    // Bus phases
    // ----------------------------------------
    assign wordIdx = apbReq.paddr[15:2];
    assign aligned = (apbReq.paddr[1:0] == 2'h0);
    assign setupPhase = apbReq.psel && !apbReq.penable;
    assign accessPhase = apbReq.psel && apbReq.penable;
    assign writeTaken = accessPhase && apbReq.pwrite && ce && aligned;

    assign apbRsp.pready = ce;
    assign apbRsp.prdata = s_reg.prdata;
    assign apbRsp.pslverr = accessPhase && !(aligned && rxsc_hit(wordIdx));

    // ----------------------------------------
    // Frame classification
    // ----------------------------------------
    // Reported length already spans addresses, payload and CRC
    assign frameErr = frameEvt.crcErr || frameEvt.anyErr;
    assign shortFrame = frameEvt.len < `RXSC_MIN_FRAME;  // R2
    assign minFrame = frameEvt.len == `RXSC_MIN_FRAME;  // R2
    assign overSize = frameEvt.len > s_reg.maxSize;  // R17

    always_comb
    begin
        incVec = '0;
        if (frameEvt.valid)
        begin
            incVec[`RXSC_C_SHORT] = frameEvt.crcErr && shortFrame;  // R9
            incVec[`RXSC_C_LONG] = frameEvt.crcErr && overSize;  // R10
            incVec[`RXSC_C_CRC] = frameEvt.crcErr && !shortFrame;  // R12
            incVec[`RXSC_C_MDATA] = frameErr && !frameEvt.isCtl && frameEvt.isMulti;  // R13
            incVec[`RXSC_C_BDATA] = frameErr && !frameEvt.isCtl && frameEvt.isBroad;  // R13
            incVec[`RXSC_C_UDATA] = frameErr && !frameEvt.isCtl && frameEvt.isUni;  // R13
            incVec[`RXSC_C_MCTL] = frameErr && frameEvt.isCtl && frameEvt.isMulti;  // R14
            incVec[`RXSC_C_BCTL] = frameErr && frameEvt.isCtl && frameEvt.isBroad;  // R14
            incVec[`RXSC_C_UCTL] = frameErr && frameEvt.isCtl && frameEvt.isUni;  // R14
            incVec[`RXSC_C_FLOW] = frameErr && frameEvt.isPause;  // R15
            incVec[`RXSC_C_MIN] = minFrame;  // R16
        end
        incVec[`RXSC_C_FCS] = checkSeqErrPulse;  // R11
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        s_next = s_reg;

        // Counting runs regardless of the shadow bit
        for (int i = 0; i < `RXSC_NUM_CNT; i++)
        begin
            if (incVec[i])
            begin
                s_next.cnt[i] = rxsc_inc(s_reg.cnt[i]);  // R1 R19
            end
        end

        // Pending clear resets the whole bank at once
        if (s_reg.ctlClear)
        begin
            s_next.cnt = '0;  // R5
            s_next.snap = '0;  // R5
            s_next.ctlClear = 1'b0;  // R18
        end

        // Register writes
        if (writeTaken)
        begin
            case (wordIdx)
                `RXSC_CTL_IDX:
                begin
                    if (apbReq.pwdata[`RXSC_CTL_CLEAR_BIT])
                    begin
                        s_next.ctlClear = 1'b1;  // R18
                    end
                    s_next.ctlShadow = apbReq.pwdata[`RXSC_CTL_SHADOW_BIT];  // R7
                    if (apbReq.pwdata[`RXSC_CTL_SHADOW_BIT] && !s_reg.ctlShadow)
                    begin
                        s_next.snap = s_reg.ctlClear ? '0 : s_reg.cnt;  // R6
                    end
                end
                `RXSC_MAXSZ_IDX:
                begin
                    s_next.maxSize = apbReq.pwdata[15:0];  // R17
                end
                default:
                begin
                    // Counter and status words ignore writes
                end
            endcase
        end

        // Read data latched in the setup phase, counters untouched
        if (setupPhase && !apbReq.pwrite)
        begin
            s_next.prdata = aligned ? rxsc_read(s_reg, wordIdx) : 32'h0000_0000;  // R4
        end

        // Without the option no counter storage survives
        if (!ENABLE_RX_STATS)
        begin
            s_next.cnt = '0;  // R3
            s_next.snap = '0;  // R3
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            s_reg <= RESET_STATE;
        end
        else if (ce)
        begin
            s_reg <= s_next;
        end
        else
        begin
            // Low clock enable freezes every field
            s_reg <= s_reg;
        end
    end

endmodule : rx_statistics_counters

// ### design/rxsc_cfg.svh
`ifndef RXSC_CFG_SVH
`define RXSC_CFG_SVH

// ----------------------------------------
// Counter bank geometry
// ----------------------------------------
`define RXSC_NUM_CNT 12
`define RXSC_CNT_BASE_IDX 14'h0900
`define RXSC_CNT_LAST_IDX 14'h0917

// ----------------------------------------
// Control and status word indices
// ----------------------------------------
`define RXSC_CTL_IDX 14'h0945
`define RXSC_STAT_IDX 14'h0946
`define RXSC_MAXSZ_IDX 14'h0947

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RXSC_CTL_CLEAR_BIT 0
`define RXSC_CTL_SHADOW_BIT 2
`define RXSC_STAT_PAUSED_BIT 1

// ----------------------------------------
// Reset values and size limits
// ----------------------------------------
`define RXSC_MAXSZ_RESET 16'h05ee
`define RXSC_MIN_FRAME 16'h0040

// ----------------------------------------
// Counter slots
// ----------------------------------------
`define RXSC_C_SHORT 4'h0
`define RXSC_C_LONG 4'h1
`define RXSC_C_FCS 4'h2
`define RXSC_C_CRC 4'h3
`define RXSC_C_MDATA 4'h4
`define RXSC_C_BDATA 4'h5
`define RXSC_C_UDATA 4'h6
`define RXSC_C_MCTL 4'h7
`define RXSC_C_BCTL 4'h8
`define RXSC_C_UCTL 4'h9
`define RXSC_C_FLOW 4'ha
`define RXSC_C_MIN 4'hb

// ----------------------------------------
// Counter word indices
// ----------------------------------------
`define RXSC_SHORT_LO_IDX 14'h0900
`define RXSC_SHORT_HI_IDX 14'h0901
`define RXSC_LONG_LO_IDX 14'h0902
`define RXSC_LONG_HI_IDX 14'h0903
`define RXSC_CHKSEQ_LO_IDX 14'h0904
`define RXSC_CHKSEQ_HI_IDX 14'h0905
`define RXSC_CRC_LO_IDX 14'h0906
`define RXSC_CRC_HI_IDX 14'h0907
`define RXSC_MDATA_LO_IDX 14'h0908
`define RXSC_MDATA_HI_IDX 14'h0909
`define RXSC_BDATA_LO_IDX 14'h090a
`define RXSC_BDATA_HI_IDX 14'h090b
`define RXSC_UDATA_LO_IDX 14'h090c
`define RXSC_UDATA_HI_IDX 14'h090d
`define RXSC_MCTL_LO_IDX 14'h090e
`define RXSC_MCTL_HI_IDX 14'h090f
`define RXSC_BCTL_LO_IDX 14'h0910
`define RXSC_BCTL_HI_IDX 14'h0911
`define RXSC_UCTL_LO_IDX 14'h0912
`define RXSC_UCTL_HI_IDX 14'h0913
`define RXSC_FLOW_LO_IDX 14'h0914
`define RXSC_FLOW_HI_IDX 14'h0915
`define RXSC_MIN_LO_IDX 14'h0916
`define RXSC_MIN_HI_IDX 14'h0917

`endif

// ### design/rxsc_pkg.sv
`include "rxsc_cfg.svh"

package rxsc_pkg;

    // ----------------------------------------
    // Bus carriers
    // ----------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } rxsc_apb_req_type;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } rxsc_apb_rsp_type;

    // ----------------------------------------
    // Per-frame report from the receive path
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic [15:0] len;
        logic crcErr;
        logic anyErr;
        logic isMulti;
        logic isBroad;
        logic isUni;
        logic isCtl;
        logic isPause;
    } rxsc_frame_type;

    // ----------------------------------------
    // Block state
    // ----------------------------------------
    typedef struct packed {
        logic [`RXSC_NUM_CNT-1:0][63:0] cnt;
        logic [`RXSC_NUM_CNT-1:0][63:0] snap;
        logic ctlClear;
        logic ctlShadow;
        logic [15:0] maxSize;
        logic [31:0] prdata;
    } rxsc_state_type;

endpackage : rxsc_pkg

// ### testbench/rxsc_frame_src.sv
`timescale 1ns/1ps
module rxsc_frame_src (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic go,
    input wire rxsc_pkg::rxsc_frame_type want,
    output rxsc_pkg::rxsc_frame_type frameEvt
);
    // One report a cycle; idle fields flip so stale values never pass
    always_ff @(posedge ref_clk)
        frameEvt <= sys_rst ? '0 : go ? want : {1'b0, ~frameEvt[22:0]};
endmodule : rxsc_frame_src

// ### testbench/rxsc_monitor.sv
`timescale 1ns/1ps
module rxsc_monitor (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire rxsc_pkg::rxsc_apb_req_type apbReq,
    input wire rxsc_pkg::rxsc_apb_rsp_type apbRsp,
    input wire rxsc_pkg::rxsc_frame_type frameEvt,
    input wire logic checkSeqErrPulse
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    wire acc = apbReq.psel && apbReq.penable;
    wire [15:0] addr = apbReq.paddr;
    wire mis = addr[1:0] != 2'b00;
    wire cntA = addr >= 16'h2400 && addr <= 16'h245c && !mis;
    wire hole = addr > 16'h245c && addr < 16'h2514;
    wire rdSet = apbReq.psel && !apbReq.penable && !apbReq.pwrite && ce;
    a_ready_ce: assert property (apbRsp.pready == ce)
        else $error("pready differs from ce");
    a_cnt_no_err: assert property (acc && cntA |-> !apbRsp.pslverr)
        else $error("error on counter word");
    a_err_access: assert property (apbRsp.pslverr |-> acc)
        else $error("error outside access");
    a_misalign_err: assert property (acc && mis |-> apbRsp.pslverr)
        else $error("misaligned accepted");
    a_hole_err: assert property (acc && hole |-> apbRsp.pslverr)
        else $error("unmapped accepted");
    a_bad_read_zero: assert property (rdSet && mis |=> apbRsp.prdata == 32'h0000_0000)
        else $error("refused read not zero");
    a_prdata_holds: assert property (!rdSet |=> $stable(apbRsp.prdata))
        else $error("read data moved");
    a_ctl_no_err: assert property (acc && addr == 16'h2514 |-> !apbRsp.pslverr)
        else $error("error on control");
endmodule : rxsc_monitor

bind rx_statistics_counters rxsc_monitor rxsc_monitor_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .ce(ce), .apbReq(apbReq), .apbRsp(apbRsp), .frameEvt(frameEvt),
    .checkSeqErrPulse(checkSeqErrPulse));

// ### testbench/testbench.sv
`timescale 1ns/1ps
`include "rxsc_cfg.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic go = 1'b0;
    logic ce = 1'b1;
    logic checkSeqErrPulse = 1'b0;
    logic errSeen;
    logic [31:0] rdData, offData;
    logic [15:0] lfsr = 16'h0013;
    logic [15:0] maxSz = `RXSC_MAXSZ_RESET;
    logic [63:0] expCnt [12];
    logic [63:0] snapCnt [12];
    rxsc_pkg::rxsc_apb_req_type apbReq = '0;
    rxsc_pkg::rxsc_apb_rsp_type apbRsp, offRsp;
    rxsc_pkg::rxsc_frame_type want = '0;
    rxsc_pkg::rxsc_frame_type frameEvt;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    always #5 ref_clk = ~ref_clk;
    rxsc_frame_src rxsc_frame_src_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .go(go),
        .want(want), .frameEvt(frameEvt));
    rx_statistics_counters rx_statistics_counters_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .ce(ce), .apbReq(apbReq), .apbRsp(apbRsp), .frameEvt(frameEvt),
        .checkSeqErrPulse(checkSeqErrPulse));
    rx_statistics_counters #(.ENABLE_RX_STATS(1'b0)) rx_statistics_counters_off_i (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .apbReq(apbReq), .apbRsp(offRsp),
        .frameEvt(frameEvt), .checkSeqErrPulse(checkSeqErrPulse));
    function automatic logic [15:0] lf();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : lf
    function automatic logic [11:0] hits(input rxsc_pkg::rxsc_frame_type f);
        logic [2:0] c;
        c = {f.isUni, f.isBroad, f.isMulti} & {3{f.crcErr | f.anyErr}};
        hits = '0;
        hits[0] = f.crcErr && f.len < 16'h0040;
        hits[1] = f.crcErr && f.len > maxSz;
        hits[3] = f.crcErr && f.len >= 16'h0040;
        hits[6:4] = f.isCtl ? 3'b000 : c;
        hits[9:7] = f.isCtl ? c : 3'b000;
        hits[10] = (f.crcErr | f.anyErr) && f.isPause;
        hits[11] = f.len == 16'h0040;
    endfunction : hits
    task automatic close_out();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        apbReq <= '{1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        apbReq.penable <= 1'b1;
        @(posedge ref_clk);
        while (apbRsp.pready !== 1'b1) @(posedge ref_clk);
        rdData = apbRsp.prdata;
        offData = offRsp.prdata;
        errSeen = apbRsp.pslverr;
        apbReq <= '0;
        @(posedge ref_clk);
    endtask : apb
    task automatic chk_bank(input bit snap);
        for (int k = 0; k < 24; k++)
        begin
            apb(1'b0, 16'h2400 + 16'(4 * k), '0);
            `CHK(rdData, (snap ? snapCnt[k / 2] : expCnt[k / 2]) >> (32 * (k % 2)))
            `CHK(offData, 32'h0000_0000)
        end
    endtask : chk_bank
    task automatic burst(input int n);
        logic [15:0] r;
        logic [11:0] h;
        rxsc_pkg::rxsc_frame_type f;
        for (int i = 0; i < n; i++)
        begin
            r = lf();
            f = {1'b1, 16'h0000, r[1:0], r[4:3] == 2'b00, r[4:3] == 2'b01, r[4], r[2], &r[3:2]};
            f.len = i == 0 ? 16'h003f : i == 1 ? 16'h0040 : i == 2 ? maxSz : {5'h00, r[15:5]};
            f.len = i == 3 ? maxSz + 16'h0001 : f.len;
            h = hits(f);
            for (int k = 0; k < 12; k++) expCnt[k] += 64'(h[k]);
            expCnt[2] += 64'(r[6]);
            go <= 1'b1;
            want <= f;
            checkSeqErrPulse <= r[6];
            @(posedge ref_clk);
        end
        go <= 1'b0;
        checkSeqErrPulse <= 1'b0;
        @(posedge ref_clk);
    endtask : burst
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            fails++;
            close_out();
        end
    end
    initial
    begin
        foreach (expCnt[k]) expCnt[k] = '0;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        apb(1'b0, 16'h251c, '0);
        `CHK(rdData, {16'h0000, `RXSC_MAXSZ_RESET})
        burst(40);
        apb(1'b1, 16'h2514, 32'h0000_0004);
        snapCnt = expCnt;
        burst(20);
        chk_bank(1'b1);
        apb(1'b0, 16'h2518, '0);
        `CHK(rdData, 32'h0000_0002)
        apb(1'b0, 16'h2514, '0);
        `CHK(rdData, 32'h0000_0004)
        apb(1'b1, 16'h2400, 32'hffff_ffff);
        apb(1'b1, 16'h2514, 32'h0000_0000);
        chk_bank(1'b0);
        apb(1'b0, 16'h2518, '0);
        `CHK(rdData, 32'h0000_0000)
        apb(1'b0, 16'h2460, '0);
        `CHK({errSeen, rdData}, 33'h0_0000_0000 | 33'h1_0000_0000)
        apb(1'b1, 16'h251c, 32'h0000_0100);
        maxSz = 16'h0100;
        apb(1'b0, 16'h251c, '0);
        `CHK(rdData, 32'h0000_0100)
        apb(1'b1, 16'h2514, 32'h0000_0001);
        foreach (expCnt[k]) expCnt[k] = '0;
        apb(1'b0, 16'h2514, '0);
        `CHK(rdData[0], 1'b0)
        burst(40);
        ce <= 1'b0;
        checkSeqErrPulse <= 1'b1;
        repeat (4) @(posedge ref_clk);
        ce <= 1'b1;
        checkSeqErrPulse <= 1'b0;
        @(posedge ref_clk);
        chk_bank(1'b0);
        close_out();
    end
endmodule : testbench
